// ### rtl/spl_top.sv
/*
 * Per-port link status register set: task file mirror, signature, link
 * status and control, error accumulation, queued tag and slot tracking.
 * Assumes register accesses are single-cycle strobes and link events are
 * one-cycle pulses synchronous to i_clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "spl_regs.svh"
module spl_top (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_command_engine_start_bit,
    input wire spl_pkg::spl_d2h_t i_d2h,
    input wire spl_pkg::spl_sdb_t i_sdb,
    input wire spl_pkg::spl_phy_t i_phy,
    input wire spl_pkg::spl_pm_req_t i_pm_req,
    input wire spl_pkg::spl_err_ev_t i_ev,
    output logic [31:0] o_reg_rdata,
    output logic o_comreset,
    output logic o_phy_offline,
    output logic [3:0] o_speed_cap,
    output logic o_partial_allowed,
    output logic o_slumber_allowed,
    output logic o_pm_nak,
    output logic o_pm_ack,
    output logic o_init_signal_irq_status,
    output logic o_phy_ready_change_irq_status
);
    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [7:0] tf_status;
        logic [7:0] tf_error;
        logic [31:0] signature;
        logic sig_taken;
        logic [31:0] active;
        logic [31:0] issue;
        logic [15:0] notify;
        logic start_q;
        logic ready_q;
        logic was_up;
        logic partial_ok;
        logic slumber_ok;
        logic [31:0] rdata;
    } spl_top_state_t;

    spl_top_state_t state;
    spl_top_state_t next_state;
    spl_pkg::spl_link_state_t link;
    logic [31:0] err_value;
    logic [31:0] err_set;
    logic wr_ctl;
    logic wr_err;
    logic stop;
    logic clean_frame;
    logic [31:0] slot_mask;
    logic [31:0] sdb_clear;
    logic [31:0] notify_set;
    logic [31:0] notify_all;
    logic wr_ntf;

    ////////////////////////////////////////////////////////////////////////
    // decode helper
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // write strobes and link events
    assign wr_ctl = i_reg_wr & hit(i_reg_addr, `SPL_OFF_CONTROL);
    assign wr_err = i_reg_wr & hit(i_reg_addr, `SPL_OFF_ERROR);
    assign wr_ntf = i_reg_wr & hit(i_reg_addr, `SPL_OFF_NOTIFY);
    assign stop = state.start_q & ~i_command_engine_start_bit;
    assign clean_frame = i_d2h.valid & ~i_d2h.status[`SPL_BIT_BUSY]
                         & ~i_d2h.status[`SPL_BIT_REQ] & ~i_d2h.status[`SPL_BIT_ERR];
    assign slot_mask = 32'h00000001 << i_d2h.slot;
    assign sdb_clear = (i_sdb.valid & i_sdb.success) ? i_sdb.active : 32'h00000000;
    assign notify_set = (i_sdb.valid & i_sdb.notify) ? (32'h00000001 << i_sdb.pm_port)
                        : 32'h00000000;

    // error and diagnostic event mapping
    always_comb begin
        err_set = 32'h00000000;
        err_set[`SPL_EB_INTERNAL] = i_ev.internal;
        err_set[`SPL_EB_PROTOCOL] = i_ev.protocol;
        err_set[`SPL_EB_PERSIST] = i_ev.persistent;
        err_set[`SPL_EB_LINK_BACK] = i_phy.ready & ~state.ready_q & state.was_up;
        err_set[`SPL_EB_DATA_UNREC] = i_ev.data_unrec;
        err_set[`SPL_EB_DATA_REC] = i_ev.data_rec;
        err_set[`SPL_EB_INIT] = i_ev.init_rx;
        err_set[`SPL_EB_WAKE] = i_ev.wake;
        err_set[`SPL_EB_READY_CHG] = i_phy.ready ^ state.ready_q;
        err_set[`SPL_EB_UNKNOWN] = i_ev.unknown_fis;
        err_set[`SPL_EB_HANDSHAKE] = i_ev.handshake;
        err_set[`SPL_EB_CRC] = i_ev.crc;
        err_set[`SPL_EB_DECODE] = i_ev.decode;
    end

    ////////////////////////////////////////////////////////////////////////
    // sub-blocks
    spl_err_acc #(
        .IMPL_MASK(`SPL_ERR_IMPL_MASK)
    ) u_err (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_clr_we(wr_err),
        .i_clr_data(i_reg_wdata),
        .i_set(err_set),
        .o_value(err_value)
    );

    spl_link_ctrl u_link (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_wr(wr_ctl),
        .i_wdata(i_reg_wdata & `SPL_CTL_WMASK | i_reg_wdata & 32'h0000000f),
        .i_start(i_command_engine_start_bit),
        .i_phy(i_phy),
        .i_pm_req(i_pm_req),
        .o_state(link)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_state = state;
        next_state.start_q = i_command_engine_start_bit;
        next_state.ready_q = i_phy.ready;
        if (i_phy.ready)
            next_state.was_up = 1'b1;
        // power permissions registered so the outputs come from flops
        next_state.partial_ok = ~link.ctl[8];
        next_state.slumber_ok = ~link.ctl[9];

        // task file mirror follows every status frame
        if (i_d2h.valid) begin
            next_state.tf_status = i_d2h.status;
            next_state.tf_error = i_d2h.error;
        end

        // signature re-arms on link reset and takes the first frame after it
        if (link.comreset)
            next_state.sig_taken = 1'b0;
        else if (i_d2h.valid & ~state.sig_taken) begin
            next_state.sig_taken = 1'b1;
            next_state.signature = {i_d2h.lba_hi, i_d2h.lba_mid,
                                    i_d2h.lba_lo, i_d2h.count};
        end

        // queued tags: completion clears, software write sets while running, stop clears all
        next_state.active = state.active & ~sdb_clear;
        if (i_reg_wr & hit(i_reg_addr, `SPL_OFF_ACTIVE) & i_command_engine_start_bit)
            next_state.active = next_state.active | i_reg_wdata;
        if (stop)
            next_state.active = 32'h00000000;

        // issue slots: clean frame clears its slot, software sets while running
        next_state.issue = clean_frame ? (state.issue & ~slot_mask) : state.issue;
        if (i_reg_wr & hit(i_reg_addr, `SPL_OFF_ISSUE) & i_command_engine_start_bit)
            next_state.issue = next_state.issue | i_reg_wdata;
        if (stop)
            next_state.issue = 32'h00000000;

        // multiplier notification, write ones to clear
        notify_all = spl_pkg::spl_sticky({16'h0000, state.notify},
                                         wr_ntf ? i_reg_wdata : 32'h00000000, notify_set);
        next_state.notify = notify_all[15:0];

        // read data, registered; unmapped addresses read zero
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                `SPL_OFF_TASKFILE: next_state.rdata = {16'h0000, state.tf_error,
                                                       state.tf_status};
                `SPL_OFF_SIGNATURE: next_state.rdata = state.signature;
                `SPL_OFF_STATUS: next_state.rdata = link.sts;
                `SPL_OFF_CONTROL: next_state.rdata = link.ctl;
                `SPL_OFF_ERROR: next_state.rdata = err_value;
                `SPL_OFF_ACTIVE: next_state.rdata = state.active;
                `SPL_OFF_ISSUE: next_state.rdata = state.issue;
                `SPL_OFF_NOTIFY: next_state.rdata = {16'h0000, state.notify};
                default: next_state.rdata = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= '0;
            state.tf_status <= `SPL_RST_TF_STATUS;
            state.tf_error <= `SPL_RST_TF_ERROR;
            state.signature <= `SPL_RST_SIGNATURE;
            state.partial_ok <= 1'b1;
            state.slumber_ok <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_reg_rdata = state.rdata;
    assign o_comreset = link.comreset;
    assign o_phy_offline = link.offline;
    assign o_speed_cap = link.ctl[7:4];
    assign o_partial_allowed = state.partial_ok;
    assign o_slumber_allowed = state.slumber_ok;
    assign o_pm_nak = link.pm_nak;
    assign o_pm_ack = link.pm_ack;
    assign o_init_signal_irq_status = err_value[`SPL_EB_INIT];
    assign o_phy_ready_change_irq_status = err_value[`SPL_EB_READY_CHG];

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);

    property p_tf_mirror;
        i_d2h.valid |=> state.tf_status == $past(i_d2h.status)
            && state.tf_error == $past(i_d2h.error);
    endproperty
    a_tf_mirror: assert property (p_tf_mirror)
        else $error("task file does not mirror the last status frame");

    property p_tf_read;
        i_reg_rd && i_reg_addr == `SPL_OFF_TASKFILE |=>
            o_reg_rdata == {16'h0000, $past(state.tf_error), $past(state.tf_status)};
    endproperty
    a_tf_read: assert property (p_tf_read)
        else $error("task file read does not return the mirror");

    property p_signature;
        i_d2h.valid && !state.sig_taken && !link.comreset |=>
            state.signature == {$past(i_d2h.lba_hi), $past(i_d2h.lba_mid),
                                $past(i_d2h.lba_lo), $past(i_d2h.count)}
            ##1 state.sig_taken;
    endproperty
    a_signature: assert property (p_signature)
        else $error("signature not captured from first frame");

    property p_comreset;
        link.ctl[3:0] == 4'h1 |=> o_comreset;
    endproperty
    a_comreset: assert property (p_comreset)
        else $error("link reset not sent while control asks for it");

    property p_offline;
        link.ctl[3:0] == 4'h4 |=> o_phy_offline && link.sts[3:0] == 4'h4;
    endproperty
    a_offline: assert property (p_offline)
        else $error("offline control not reflected in status");

    property p_linked;
        link.ctl[3:0] == 4'h0 && i_phy.ready |=> link.sts[3:0] == 4'h3
            && link.sts[7:4] == {2'b00, $past(i_phy.gen)};
    endproperty
    a_linked: assert property (p_linked)
        else $error("detection or speed wrong with link up");

    property p_nolink;
        !i_phy.ready |=> link.sts[7:4] == 4'h0 && link.sts[11:8] == 4'h0;
    endproperty
    a_nolink: assert property (p_nolink)
        else $error("speed or power not zero without link");

    property p_slumber;
        i_phy.ready && i_phy.slumber |=> link.sts[11:8] == 4'h6;
    endproperty
    a_slumber: assert property (p_slumber)
        else $error("slumber not reported");

    property p_partial;
        i_phy.ready && i_phy.partial && !i_phy.slumber |=> link.sts[11:8] == 4'h2;
    endproperty
    a_partial: assert property (p_partial)
        else $error("partial not reported");

    property p_pm_refuse;
        i_pm_req.valid && (i_pm_req.slumber ? link.ctl[9] : link.ctl[8])
            |=> o_pm_nak && !o_pm_ack;
    endproperty
    a_pm_refuse: assert property (p_pm_refuse)
        else $error("request for disabled power state not refused");

    property p_err_set;
        i_ev.internal |=> err_value[`SPL_EB_INTERNAL];
    endproperty
    a_err_set: assert property (p_err_set)
        else $error("internal error not recorded");

    property p_crc_set;
        i_ev.crc |=> err_value[`SPL_EB_CRC];
    endproperty
    a_crc_set: assert property (p_crc_set)
        else $error("crc error not recorded");

    property p_ready_chg;
        i_phy.ready != $past(i_phy.ready) |=> err_value[`SPL_EB_READY_CHG];
    endproperty
    a_ready_chg: assert property (p_ready_chg)
        else $error("phy ready change not recorded");

    property p_link_back;
        $rose(i_phy.ready) && state.was_up |=> err_value[`SPL_EB_LINK_BACK];
    endproperty
    a_link_back: assert property (p_link_back)
        else $error("link recovery not recorded");

    property p_diag_zero;
        err_value[24] == 1'b0 && err_value[20] == 1'b0 && err_value[17] == 1'b0;
    endproperty
    a_diag_zero: assert property (p_diag_zero)
        else $error("constant-zero diagnostic bit set");

    property p_stop_clears;
        stop |=> state.active == 32'h00000000 && state.issue == 32'h00000000;
    endproperty
    a_stop_clears: assert property (p_stop_clears)
        else $error("stop did not clear active and issue");

    property p_issue_clear;
        clean_frame && !i_reg_wr && !stop |=> !state.issue[$past(i_d2h.slot)];
    endproperty
    a_issue_clear: assert property (p_issue_clear)
        else $error("issue bit kept after clean status frame");

    property p_active_clear;
        i_sdb.valid && i_sdb.success && !i_reg_wr |=> (state.active & $past(i_sdb.active)) == 0;
    endproperty
    a_active_clear: assert property (p_active_clear)
        else $error("completed tag still active");

    c_comreset: cover property (o_comreset [*3] ##1 !o_comreset);
    c_nak: cover property (i_pm_req.valid ##1 o_pm_nak);
    c_link_back: cover property ($rose(i_phy.ready) && state.was_up);
    c_issue_done: cover property (state.issue != 32'h00000000 ##[1:20]
                                  state.issue == 32'h00000000);
endmodule
`default_nettype wire

// ### rtl/spl_regs.svh
/*
 * Offsets, field positions, reset values and error bit positions of the
 * per-port link status register set.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef SPL_REGS_SVH
`define SPL_REGS_SVH
`define SPL_OFF_TASKFILE 8'h20
`define SPL_OFF_SIGNATURE 8'h24
`define SPL_OFF_STATUS 8'h28
`define SPL_OFF_CONTROL 8'h2c
`define SPL_OFF_ERROR 8'h30
`define SPL_OFF_ACTIVE 8'h34
`define SPL_OFF_ISSUE 8'h38
`define SPL_OFF_NOTIFY 8'h3c
`define SPL_RST_TF_STATUS 8'h7f
`define SPL_RST_TF_ERROR 8'h00
`define SPL_RST_SIGNATURE 32'h0fffffff
`define SPL_CTL_WMASK 32'h00000ff0
`define SPL_ERR_IMPL_MASK 32'h066d0f03
`define SPL_BIT_BUSY 7
`define SPL_BIT_REQ 3
`define SPL_BIT_ERR 0
`define SPL_EB_INTERNAL 11
`define SPL_EB_PROTOCOL 10
`define SPL_EB_PERSIST 9
`define SPL_EB_DATA_UNREC 8
`define SPL_EB_LINK_BACK 1
`define SPL_EB_DATA_REC 0
`define SPL_EB_INIT 26
`define SPL_EB_UNKNOWN 25
`define SPL_EB_HANDSHAKE 22
`define SPL_EB_CRC 21
`define SPL_EB_DECODE 19
`define SPL_EB_WAKE 18
`define SPL_EB_READY_CHG 16
`endif

// ### rtl/spl_pkg.sv
/*
 * Types shared by the link status register set.
 * Assumes the constants header is included by the design files.
 */
package spl_pkg;
    typedef enum logic [3:0] {
        SPL_DET_NONE = 4'h0,
        SPL_DET_PRESENT = 4'h1,
        SPL_DET_LINKED = 4'h3,
        SPL_DET_OFFLINE = 4'h4
    } spl_det_t;
    typedef struct packed {
        logic valid;
        logic [7:0] status;
        logic [7:0] error;
        logic [7:0] lba_hi;
        logic [7:0] lba_mid;
        logic [7:0] lba_lo;
        logic [7:0] count;
        logic [4:0] slot;
    } spl_d2h_t;
    typedef struct packed {
        logic valid;
        logic success;
        logic [31:0] active;
        logic notify;
        logic [3:0] pm_port;
    } spl_sdb_t;
    typedef struct packed {
        logic present;
        logic ready;
        logic [1:0] gen;
        logic partial;
        logic slumber;
    } spl_phy_t;
    typedef struct packed {
        logic valid;
        logic slumber;
    } spl_pm_req_t;
    typedef struct packed {
        logic internal;
        logic protocol;
        logic persistent;
        logic data_unrec;
        logic data_rec;
        logic init_rx;
        logic wake;
        logic unknown_fis;
        logic handshake;
        logic crc;
        logic decode;
    } spl_err_ev_t;
    typedef struct packed {
        logic [31:0] ctl;
        logic [31:0] sts;
        logic comreset;
        logic offline;
        logic pm_nak;
        logic pm_ack;
    } spl_link_state_t;
    // sticky update where a new set wins over a same-cycle clear
    function automatic logic [31:0] spl_sticky(input logic [31:0] old,
                                               input logic [31:0] clr,
                                               input logic [31:0] set);
        spl_sticky = (old & ~clr) | set;
    endfunction
endpackage

// ### rtl/spl_err_acc.sv
/*
 * Accumulating write-ones-to-clear error and diagnostic register.
 * Assumes the caller presents one-cycle set pulses already mapped to bits.
 */
`timescale 1ns/1ns
`default_nettype none
`include "spl_regs.svh"
module spl_err_acc #(
    parameter logic [31:0] IMPL_MASK = `SPL_ERR_IMPL_MASK
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_clr_we,
    input wire logic [31:0] i_clr_data,
    input wire logic [31:0] i_set,
    output logic [31:0] o_value
);
    logic [31:0] state;
    logic [31:0] next_state;
    // a mask that would let constant-zero bits set is refused at elaboration
    if (IMPL_MASK[24] | IMPL_MASK[20] | IMPL_MASK[17]) begin : g_bad_mask
        $error("spl_err_acc: bits 24, 20, 17 must stay unimplemented");
    end
    // constant-zero bits are masked off the set path
    always_comb begin
        next_state = spl_pkg::spl_sticky(state, i_clr_we ? i_clr_data : 32'h00000000,
                                         i_set) & IMPL_MASK;
    end
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= 32'h00000000;
        end else begin
            state <= next_state;
        end
    end
    assign o_value = state;
endmodule
`default_nettype wire

// ### rtl/spl_link_ctrl.sv
/*
 * Link control register, link status reporting and power request refusal.
 * Assumes phy inputs are synchronous levels and requests are one-cycle pulses.
 */
`timescale 1ns/1ns
`default_nettype none
`include "spl_regs.svh"
module spl_link_ctrl (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_wr,
    input wire logic [31:0] i_wdata,
    input wire logic i_start,
    input wire spl_pkg::spl_phy_t i_phy,
    input wire spl_pkg::spl_pm_req_t i_pm_req,
    output spl_pkg::spl_link_state_t o_state
);
    spl_pkg::spl_link_state_t state;
    spl_pkg::spl_link_state_t next_state;
    logic [3:0] det_ctl;
    logic refuse;
    always_comb begin
        next_state = state;
        // detection code is held while the engine runs; speed and power are free
        if (i_wr) begin
            next_state.ctl[11:4] = i_wdata[11:4];
            if (!i_start)
                next_state.ctl[3:0] = i_wdata[3:0];
        end
        det_ctl = state.ctl[3:0];
        next_state.comreset = (det_ctl == 4'h1);
        next_state.offline = (det_ctl == 4'h4);
        // detection field
        if (det_ctl == 4'h4)
            next_state.sts[3:0] = spl_pkg::SPL_DET_OFFLINE;
        else if (i_phy.ready)
            next_state.sts[3:0] = spl_pkg::SPL_DET_LINKED;
        else if (i_phy.present)
            next_state.sts[3:0] = spl_pkg::SPL_DET_PRESENT;
        else
            next_state.sts[3:0] = spl_pkg::SPL_DET_NONE;
        // speed and power fields read zero without a link
        next_state.sts[7:4] = i_phy.ready ? {2'b00, i_phy.gen} : 4'h0;
        if (!i_phy.ready)
            next_state.sts[11:8] = 4'h0;
        else if (i_phy.slumber)
            next_state.sts[11:8] = 4'h6;
        else if (i_phy.partial)
            next_state.sts[11:8] = 4'h2;
        else
            next_state.sts[11:8] = 4'h1;
        next_state.sts[31:12] = 20'h00000;
        // device requests for a disabled state are refused
        refuse = i_pm_req.slumber ? state.ctl[9] : state.ctl[8];
        next_state.pm_nak = i_pm_req.valid & refuse;
        next_state.pm_ack = i_pm_req.valid & ~refuse;
    end
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
    assign o_state = state;
endmodule
`default_nettype wire

// ### rtl/spl_top_unused_guard.sv
/*
 * Holds no logic; the block lives in the other rtl files.
 */

// ### verification/spl_drive_model.sv
/* drive side model: phy levels, received frames, power requests.
   assumes the bench calls its tasks; lines change 1 ns after the edge. */
`timescale 1ns/1ns
`default_nettype none
module spl_drive_model (
    input wire logic i_clock,
    input wire logic i_comreset,
    output spl_pkg::spl_phy_t o_phy,
    output spl_pkg::spl_d2h_t o_d2h,
    output spl_pkg::spl_sdb_t o_sdb,
    output spl_pkg::spl_pm_req_t o_pm_req
);
    spl_pkg::spl_phy_t lvl;
    // link drops while the adapter sends link reset
    assign o_phy = i_comreset ? (lvl & 6'h20) : lvl;
    initial begin
        lvl = '0;
        o_d2h = '0;
        o_sdb = '0;
        o_pm_req = '0;
    end
    // levels settle one edge before the task returns
    task automatic phy(input logic [5:0] p);
        @(posedge i_clock) #1 lvl = p;
        @(posedge i_clock);
    endtask
    // one-cycle frames, then released lines show the inverse
    task automatic d2h(input logic [52:0] f);
        @(posedge i_clock) #1 o_d2h = {1'b1, f};
        @(posedge i_clock) #1 o_d2h = {1'b0, ~f};
    endtask
    task automatic sdb(input logic [37:0] f);
        @(posedge i_clock) #1 o_sdb = {1'b1, f};
        @(posedge i_clock) #1 o_sdb = {1'b0, ~f};
    endtask
    task automatic pm(input logic s);
        @(posedge i_clock) #1 o_pm_req = {1'b1, s};
        @(posedge i_clock) #1 o_pm_req = {1'b0, ~s};
    endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
/* bench for the link status register set: register tasks and tests.
   assumes spl_top and the drive model. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
    logic i_clock;
    logic i_reset_n;
    logic i_reg_wr;
    logic i_reg_rd;
    logic start;
    logic [7:0] i_reg_addr;
    logic [31:0] i_reg_wdata, o_reg_rdata, got;
    spl_pkg::spl_err_ev_t i_ev;
    spl_pkg::spl_d2h_t i_d2h;
    spl_pkg::spl_sdb_t i_sdb;
    spl_pkg::spl_phy_t i_phy;
    spl_pkg::spl_pm_req_t i_pm_req;
    logic o_comreset, o_phy_offline, o_partial_allowed, o_slumber_allowed, o_pm_nak, o_pm_ack;
    logic o_init_signal_irq_status, o_phy_ready_change_irq_status;
    logic [3:0] o_speed_cap;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int pos[11] = '{11, 10, 9, 8, 0, 26, 18, 25, 22, 21, 19};
    spl_top dut (.i_clock, .i_reset_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
        .i_command_engine_start_bit(start), .i_d2h, .i_sdb, .i_phy, .i_pm_req, .i_ev,
        .o_reg_rdata, .o_comreset, .o_phy_offline, .o_speed_cap, .o_partial_allowed,
        .o_slumber_allowed, .o_pm_nak, .o_pm_ack, .o_init_signal_irq_status,
        .o_phy_ready_change_irq_status);
    spl_drive_model drv (.i_clock, .i_comreset(o_comreset), .o_phy(i_phy), .o_d2h(i_d2h),
        .o_sdb(i_sdb), .o_pm_req(i_pm_req));
    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end
    // a hang counts as a mismatch
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // register strobes last one cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock) #1 {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, d};
        @(posedge i_clock) #1 i_reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clock) #1 {i_reg_rd, i_reg_addr} = {1'b1, a};
        @(posedge i_clock) #1 i_reg_rd = 1'b0;
        got = o_reg_rdata;
    endtask
    task automatic chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        rd(a);
        `CHK(nm, e, got)
    endtask
    task automatic ev(input logic [10:0] e);
        @(posedge i_clock) #1 i_ev = e;
        @(posedge i_clock) #1 i_ev = '0;
    endtask
    task automatic st(input logic v);
        @(posedge i_clock) #1 start = v;
    endtask
    // test sequence
    initial begin
        i_reset_n = 1'b0;
        {i_reg_wr, i_reg_rd, start, i_reg_addr, i_reg_wdata} = '0;
        i_ev = '0;
        repeat (8) @(posedge i_clock);
        #1 i_reset_n = 1'b1;
        chk("taskfile", 8'h20, 32'h7f);
        chk("signature", 8'h24, 32'h0fffffff);
        chk("queue", 8'h34, 32'h0);
        chk("issue", 8'h38, 32'h0);
        chk("unmapped", 8'h40, 32'h0);
        $display("test reset done");
        drv.phy(6'h20);
        chk("status", 8'h28, 32'h001);
        drv.phy(6'h34);
        chk("status", 8'h28, 32'h113);
        drv.phy(6'h3a);
        chk("status", 8'h28, 32'h223);
        drv.phy(6'h39);
        chk("status", 8'h28, 32'h623);
        drv.phy(6'h00);
        chk("status", 8'h28, 32'h000);
        drv.phy(6'h38);
        $display("test status done");
        wr(8'h30, '1);
        chk("error", 8'h30, 32'h0);
        for (int i = 0; i < 11; i++) begin
            ev(11'h400 >> i);
            chk("error", 8'h30, 32'h1 << pos[i]);
            `CHK("init_irq", pos[i] == 26, o_init_signal_irq_status)
            wr(8'h30, 32'h1 << pos[i]);
        end
        drv.phy(6'h28);
        chk("error", 8'h30, 32'h10000);
        `CHK("ready_irq", 1'b1, o_phy_ready_change_irq_status)
        wr(8'h30, '1);
        drv.phy(6'h38);
        chk("error", 8'h30, 32'h10002);
        $display("test error done");
        wr(8'h2c, 32'h1);
        chk("control", 8'h2c, 32'h1);
        `CHK("comreset", 1'b1, o_comreset)
        repeat (16) @(posedge i_clock); // hold kept short to bound run time
        #1 `CHK("comreset_hold", 1'b1, o_comreset)
        wr(8'h2c, 32'h0);
        drv.d2h({8'h50, 8'h00, 8'h12, 8'h34, 8'h56, 8'h78, 5'd0});
        drv.d2h({8'h89, 8'h04, 8'h9a, 8'hbc, 8'hde, 8'hf0, 5'd1});
        chk("signature", 8'h24, 32'h12345678);
        chk("taskfile", 8'h20, 32'h0489);
        wr(8'h2c, 32'h4);
        rd(8'h28);
        `CHK("det", 4'h4, got[3:0])
        `CHK("offline", 1'b1, o_phy_offline)
        for (int c = 0; c < 3; c++) begin
            wr(8'h2c, c << 4);
            chk("control", 8'h2c, c << 4);
            `CHK("cap", 4'(c), o_speed_cap)
        end
        $display("test control done");
        for (int m = 0; m < 4; m++) begin
            wr(8'h2c, m << 8);
            chk("control", 8'h2c, m << 8);
            `CHK("partial_ok", ~m[0], o_partial_allowed)
            `CHK("slumber_ok", ~m[1], o_slumber_allowed)
            drv.pm(1'b0);
            `CHK("nak", m[0], o_pm_nak)
            `CHK("ack", ~m[0], o_pm_ack)
            drv.pm(1'b1);
            `CHK("nak", m[1], o_pm_nak)
        end
        $display("test power done");
        st(1'b1);
        wr(8'h2c, 32'h301);
        chk("control", 8'h2c, 32'h300);
        wr(8'h34, 32'h5);
        wr(8'h38, 32'h5);
        drv.d2h({8'h50, 8'h00, 32'h0, 5'd0});
        drv.d2h({8'h58, 8'h00, 32'h0, 5'd2});
        chk("issue", 8'h38, 32'h4);
        drv.sdb({1'b1, 32'h1, 1'b1, 4'h3});
        drv.sdb({1'b0, 32'h4, 1'b0, 4'h0});
        chk("queue", 8'h34, 32'h4);
        chk("notify", 8'h3c, 32'h8);
        wr(8'h3c, 32'h8);
        chk("notify", 8'h3c, 32'h0);
        st(1'b0);
        chk("queue", 8'h34, 32'h0);
        chk("issue", 8'h38, 32'h0);
        wr(8'h38, 32'h1);
        chk("issue", 8'h38, 32'h0);
        $display("test queue done");
        final_report();
    end
endmodule
`default_nettype wire
